// ### flash_reset_pkg.sv
package flash_reset_pkg;
	// ======================================================
	// clock and timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int RESET_LOW_MIN_WIDTH_NS = 100;
	localparam int RESET_ABORT_TIME_US = 25;
	localparam int SUPPLY_TO_RESET_RELEASE_OLD_US = 60;
	localparam int SUPPLY_TO_RESET_RELEASE_NEW_US = 300;
	localparam int ERASE_TO_SUSPEND_SPACING_US = 500;
	// reset-low and supply times round up, abort and spacing times round down
	localparam int RESET_LOW_MIN_CYC =
		(RESET_LOW_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ABORT_MAX_CYC =
		(RESET_ABORT_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int SUPPLY_OLD_CYC =
		(SUPPLY_TO_RESET_RELEASE_OLD_US * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int SUPPLY_NEW_CYC =
		(SUPPLY_TO_RESET_RELEASE_NEW_US * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int SPACING_CYC =
		(ERASE_TO_SUSPEND_SPACING_US * 1000) / CLK_PERIOD_NS;
	// abort takes part of the allowed window; half of the maximum
	localparam int ABORT_CYC = ABORT_MAX_CYC / 2;
	localparam int CNT_W = 16;
	// ======================================================
	// status and modes
	localparam logic [7:0] STATUS_RESET = 8'h80;
	typedef enum logic [2:0] {
		ST_POWERDOWN = 3'b000,
		ST_WAKE      = 3'b001,
		ST_READ      = 3'b010,
		ST_BUSY      = 3'b011,
		ST_ABORT     = 3'b100,
		ST_HELD      = 3'b101
	} dev_state_t;
endpackage : flash_reset_pkg

// ### cycle_timer.sv
`timescale 1ns/1ps
`default_nettype none
// ======================================================
// loadable down counter, done while zero and not loading
module cycle_timer (
	// clock and reset
	input  wire  logic                           clk,
	input  wire  logic                           rst,
	// control
	input  wire  logic                           load,
	input  wire  logic [flash_reset_pkg::CNT_W-1:0] value,
	// status
	output logic                                 done
);
	import flash_reset_pkg::*;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;
	// load wins over counting so a restart is never lost
	always_comb begin
		next_count = count;
		if (load) begin
			next_count = value;
		end else if (count != '0) begin
			next_count = count - 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end
	assign done = (count == '0) && !load;
endmodule : cycle_timer
`default_nettype wire

// ### flash_reset_core.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - reset during program or erase aborts and resets within 25 us
// - reset with no operation running completes within the pulse width
// - tied-high reset: not ready until supply interval elapsed
// - while reset asserted all control inputs are ignored
// - after reset: array read mode, status 0x80
// - aborted program or erase is terminated, contents undefined
module flash_reset_core (
	// clock and reset
	input  wire  logic       REF_CLK,
	input  wire  logic       RST,
	// flash pins and supply
	input  wire  logic       RESET_N,
	input  wire  logic       SUPPLY_VALID,
	input  wire  logic       NEW_PROCESS,
	// decoded commands
	input  wire  logic       START_OP,
	input  wire  logic       ERASE_OP,
	input  wire  logic       SUSPEND_CMD,
	input  wire  logic       OP_DONE,
	// state
	output logic             READY,
	output logic             ARRAY_READ,
	output logic             OP_BUSY,
	output logic             ABORTED,
	output logic             SPACING_VIOLATION,
	output logic [7:0]       STATUS
);
	import flash_reset_pkg::*;
	// ======================================================
	// state
	dev_state_t  state;
	dev_state_t  next_state;
	logic [7:0]  next_status;
	logic        next_aborted;
	logic        next_erasing;
	logic        erasing;
	logic        next_violation;
	logic        t_load;
	logic [CNT_W-1:0] t_value;
	logic        t_done;
	logic        s_load;
	logic        s_done;
	logic        accept;
	// erase starts only count while out of reset and ready
	assign accept = RESET_N && (state == ST_READ);
	cycle_timer u_wait (
		.clk   (REF_CLK),
		.rst   (RST),
		.load  (t_load),
		.value (t_value),
		.done  (t_done)
	);
	// spacing timer restarts on every erase start or resume
	assign s_load = accept && START_OP && ERASE_OP;
	cycle_timer u_space (
		.clk   (REF_CLK),
		.rst   (RST),
		.load  (s_load),
		.value (CNT_W'(SPACING_CYC)),
		.done  (s_done)
	);
	// ======================================================
	// next state
	always_comb begin
		next_state     = state;
		next_status    = STATUS;
		next_aborted   = ABORTED;
		next_erasing   = erasing;
		next_violation = 1'b0;
		t_load         = 1'b0;
		t_value        = '0;
		unique case (state)
			ST_POWERDOWN: begin
				// supply interval counted even when reset is tied high
				if (SUPPLY_VALID) begin
					t_load     = 1'b1;
					t_value    = NEW_PROCESS ? CNT_W'(SUPPLY_NEW_CYC)
					                         : CNT_W'(SUPPLY_OLD_CYC);
					next_state = ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (t_done && RESET_N) begin
					next_state  = ST_READ;
					next_status = STATUS_RESET;
				end
			end
			ST_READ: begin
				if (!RESET_N) begin
					// idle reset finishes at once, within the pulse
					next_state  = ST_HELD;
					next_status = STATUS_RESET;
				end else if (START_OP) begin
					next_state   = ST_BUSY;
					next_erasing = ERASE_OP;
					next_aborted = 1'b0;
					next_status  = 8'h00;
				end else if (SUSPEND_CMD && !s_done) begin
					next_violation = 1'b1;
				end
			end
			ST_BUSY: begin
				if (!RESET_N) begin
					t_load     = 1'b1;
					t_value    = CNT_W'(ABORT_CYC);
					next_state = ST_ABORT;
				end else if (SUSPEND_CMD && erasing && !s_done) begin
					next_violation = 1'b1;
				end else if (OP_DONE) begin
					next_state  = ST_READ;
					next_status = STATUS_RESET;
				end
			end
			ST_ABORT: begin
				// operation terminated; its target left undefined
				if (t_done) begin
					next_state   = ST_HELD;
					next_aborted = 1'b1;
					next_status  = STATUS_RESET;
				end
			end
			ST_HELD: begin
				if (RESET_N) begin
					next_state  = ST_READ;
					next_status = STATUS_RESET;
				end
			end
			default: begin
				next_state = ST_POWERDOWN;
			end
		endcase
		if (!SUPPLY_VALID) begin
			next_state = ST_POWERDOWN;
		end
	end
	// ======================================================
	// registers
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			state             <= ST_POWERDOWN;
			STATUS            <= STATUS_RESET;
			ABORTED           <= 1'b0;
			erasing           <= 1'b0;
			SPACING_VIOLATION <= 1'b0;
		end else begin
			state             <= next_state;
			STATUS            <= next_status;
			ABORTED           <= next_aborted;
			erasing           <= next_erasing;
			SPACING_VIOLATION <= next_violation;
		end
	end
	assign READY      = (state == ST_READ);
	assign ARRAY_READ = (state == ST_READ);
	assign OP_BUSY    = (state == ST_BUSY) || (state == ST_ABORT);
	// ======================================================
	// checks
	int abort_cnt;
	always_ff @(posedge REF_CLK) begin
		if (RST || state != ST_ABORT) begin
			abort_cnt <= 0;
		end else begin
			abort_cnt <= abort_cnt + 1;
		end
	end
	// age of the last accepted erase or resume, kept apart from the timer;
	// it saturates so a long idle spell cannot wrap into a false suspend
	int since_erase;
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			since_erase <= SPACING_CYC;
		end else if (s_load) begin
			since_erase <= 0;
		end else if (since_erase < SPACING_CYC) begin
			since_erase <= since_erase + 1;
		end
	end
	AST_ABORT_BOUND: assert property (
		@(posedge REF_CLK) disable iff (RST)
		abort_cnt <= ABORT_MAX_CYC)
		else $error("abort exceeded allowed time");
	// the abort must end at its own count; a counter replaces a long range
	AST_ABORT_END: assert property (
		@(posedge REF_CLK) disable iff (RST)
		state == ST_ABORT |-> abort_cnt <= ABORT_CYC)
		else $error("abort never completes");
	AST_IDLE_RESET: assert property (
		@(posedge REF_CLK) disable iff (RST)
		(state == ST_READ && !RESET_N && SUPPLY_VALID) |=> state == ST_HELD)
		else $error("idle reset not immediate");
	AST_IGNORE_CMDS: assert property (
		@(posedge REF_CLK) disable iff (RST)
		(state == ST_HELD && !RESET_N) |=> !OP_BUSY)
		else $error("command started during reset");
	AST_STATUS_INIT: assert property (
		@(posedge REF_CLK) disable iff (RST)
		$rose(READY) |-> STATUS == STATUS_RESET)
		else $error("status not initialised on ready");
	AST_NOT_READY_EARLY: assert property (
		@(posedge REF_CLK) disable iff (RST)
		$rose(SUPPLY_VALID) |=> !READY [*8])
		else $error("ready before supply interval");
	AST_ABORT_FLAG: assert property (
		@(posedge REF_CLK) disable iff (RST)
		(state == ST_ABORT && t_done && SUPPLY_VALID) |=> ABORTED)
		else $error("abort not recorded");
	// any suspend with reset released inside the spacing window of a running erase is flagged
	AST_SPACING: assert property (
		@(posedge REF_CLK) disable iff (RST)
		(SUSPEND_CMD && RESET_N && SUPPLY_VALID && state == ST_BUSY
		&& erasing && since_erase < SPACING_CYC) |=> SPACING_VIOLATION)
		else $error("early suspend not flagged");
	AST_NO_FALSE_VIOL: assert property (
		@(posedge REF_CLK) disable iff (RST)
		!(SUSPEND_CMD && since_erase < SPACING_CYC) |=> !SPACING_VIOLATION)
		else $error("suspend flagged without cause");
	COV_ABORT: cover property (@(posedge REF_CLK) disable iff (RST)
		state == ST_ABORT ##1 state == ST_HELD);
	COV_IDLE: cover property (@(posedge REF_CLK) disable iff (RST)
		state == ST_READ ##1 state == ST_HELD);
	COV_VIOL: cover property (@(posedge REF_CLK) disable iff (RST)
		SPACING_VIOLATION);
	COV_READY: cover property (@(posedge REF_CLK) disable iff (RST)
		$rose(READY));
	COV_LATE_SUSPEND: cover property (@(posedge REF_CLK) disable iff (RST)
		SUSPEND_CMD && state == ST_BUSY && since_erase >= SPACING_CYC);
endmodule : flash_reset_core
`default_nettype wire

// ### host_reset_model.sv
`timescale 1ns/1ps
`default_nettype none
// ======================================================
// host side that owns the flash reset pin
module host_reset_model (
	// clock
	input  wire logic clk,
	// supply and requests
	input  wire logic supply_ok,
	input  wire logic new_proc,
	input  wire logic hold,
	input  wire logic tie_high,
	// flash pin
	output logic      reset_n
);
	import flash_reset_pkg::*;
	int   wait_cnt = 0;
	int   low_cnt  = 0;
	int   need;
	logic drive_n  = 1'b0;
	assign need = new_proc ? SUPPLY_NEW_CYC : SUPPLY_OLD_CYC;
	// waits counted in whole cycles, rounded up
	always @(posedge clk) begin
		wait_cnt <= supply_ok ? wait_cnt + 1 : 0;
		low_cnt  <= drive_n ? 0 : low_cnt + 1;
	end
	// the pin is a register so its own low count cannot make it chatter
	// low while ramping hold mirrors the cpu reset
	always @(posedge clk) begin
		if (!supply_ok || hold) begin
			drive_n <= 1'b0;
		end else if (wait_cnt >= need && low_cnt >= RESET_LOW_MIN_CYC) begin
			drive_n <= 1'b1; // minimum low width kept
		end
	end
	assign reset_n = tie_high | drive_n;
endmodule : host_reset_model
`default_nettype wire

// ### tb_flash_reset_and_suspend_timing.sv
`timescale 1ns/1ps
`default_nettype none
module tb_flash_reset_and_suspend_timing;
	import flash_reset_pkg::*;
	logic clk = 0, rst = 1, supply = 0, newp = 0, start = 0, erase = 0;
	logic susp = 0, done = 0, hold = 0, tie = 0;
	logic ready, aread, busy, aborted, viol;
	logic [7:0] status;
	wire logic reset_n;
	int num_errors = 0, checks_done = 0, n, g;
	always #50 clk = ~clk;
	flash_reset_core dut (.REF_CLK(clk), .RST(rst), .RESET_N(reset_n),
		.SUPPLY_VALID(supply), .NEW_PROCESS(newp), .START_OP(start),
		.ERASE_OP(erase), .SUSPEND_CMD(susp), .OP_DONE(done),
		.READY(ready), .ARRAY_READ(aread), .OP_BUSY(busy),
		.ABORTED(aborted), .SPACING_VIOLATION(viol), .STATUS(status));
	host_reset_model host (.clk(clk), .supply_ok(supply), .new_proc(newp),
		.hold(hold), .tie_high(tie), .reset_n(reset_n));
	task check(input string what, input logic [7:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task stop_test;
		if (num_errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test
	task tick(input int k);
		repeat (k) @(negedge clk);
	endtask : tick
	task pulse(input logic e);
		start = 1;
		erase = e;
		tick(1);
		start = 0;
		erase = 0;
	endtask : pulse
	task wait_ready;
		n = 0;
		while (ready !== 1'b1 && n < 4000) begin
			tick(1);
			n++;
		end
		check("ready", 8'(ready), 8'h01);
	endtask : wait_ready
	// ======================================================
	// main sequence
	initial begin
		void'($urandom(32'h92b6));
		tick(12);
		rst = 0;
		// power-up: pin tied high on the newer process, then host-driven
		for (int i = 0; i < 2; i++) begin
			supply = 0;
			tie = (i == 0);
			newp = (i == 0);
			tick(3);
			supply = 1;
			wait_ready;
			g = newp ? SUPPLY_NEW_CYC : SUPPLY_OLD_CYC;
			check("ready_delay", 8'(n >= g && n <= g + 4), 8'h01);
			check("status", status, STATUS_RESET);
			check("array_read", 8'(aread), 8'h01);
		end
		// suspend early at a random gap, then late
		for (int k = 0; k < 2; k++) begin
			pulse(1);
			g = k ? SPACING_CYC + 2 : $urandom_range(SPACING_CYC - 10, 1);
			tick(g);
			susp = 1;
			tick(1);
			susp = 0;
			// the flag stands for the one cycle after the suspend edge
			check("spacing", 8'(viol), 8'(g + 1 < SPACING_CYC));
			tick(2);
			done = 1;
			tick(1);
			done = 0;
			wait_ready;
		end
		// reset in mid-program must abort in time
		pulse(0);
		tick(1 + $urandom_range(20));
		check("busy", 8'(busy), 8'h01);
		hold = 1;
		n = 0;
		while (busy === 1'b1 && n < 3000) begin
			tick(1);
			n++;
		end
		check("abort_time", 8'(n <= ABORT_MAX_CYC), 8'h01);
		check("aborted", 8'(aborted), 8'h01);
		pulse(0);
		tick(2);
		check("ignored", 8'(busy), 8'h00);
		hold = 0;
		wait_ready;
		check("status_after", status, STATUS_RESET);
		// idle reset needs no abort time
		hold = 1;
		tick(RESET_LOW_MIN_CYC + 1);
		check("idle_reset", 8'(ready), 8'h00);
		hold = 0;
		wait_ready;
		check("idle_recover", 8'(n <= 4), 8'h01);
		pulse(0);
		tick(1);
		check("aborted_clear", 8'(aborted), 8'h00);
		stop_test;
	end
	// watchdog well beyond the longest expected run
	initial begin
		#(60_000 * 100);
		num_errors++;
		stop_test;
	end
endmodule : tb_flash_reset_and_suspend_timing
`default_nettype wire
